// file: rtl/srp_cfg.svh
// constants for the serial receiver path: register offsets, field positions, reset values, timing
`ifndef SRP_CFG_SVH
`define SRP_CFG_SVH
// register offsets
`define SRP_CTRL_OFS      4'h0
`define SRP_STAT_OFS      4'h1
`define SRP_DATA_OFS      4'h2
`define SRP_BAUD_OFS      4'h3
// control register fields
`define SRP_CTRL_SERIAL_PORT_ENABLE     0
`define SRP_CTRL_CONTINUOUS_RECEIVE_ENABLE     1
`define SRP_CTRL_SINGLE_RECEIVE_ENABLE     2
`define SRP_CTRL_RX9      3
`define SRP_CTRL_ADDRESS_DETECT_ENABLE    4
`define SRP_CTRL_SYNC     5
`define SRP_CTRL_MASTER   6
`define SRP_CTRL_WAKE     7
`define SRP_CTRL_RXIE     8
`define SRP_CTRL_PERIPHERAL_IRQ_ENABLE     9
`define SRP_CTRL_GIE      10
`define SRP_CTRL_SLEEP    11
// status register fields
`define SRP_STAT_FLAG     0
`define SRP_STAT_FRAMING_ERROR_BIT     1
`define SRP_STAT_OVERRUN_ERROR_BIT     2
`define SRP_STAT_D9       3
`define SRP_STAT_BREAK    4
`define SRP_STAT_WAKE     5
`define SRP_STAT_BUSY     6
// reset values
`define SRP_CTRL_RST      12'h000
`define SRP_BAUD_RST      16'h0000
// timing and fifo size
`define SRP_CLK_MHZ       100
`define SRP_FIFO_DEPTH    2
`endif

// file: rtl/srp_pkg.sv
// types for the serial receiver path
package srp_pkg;
   typedef enum logic [2:0] {
      SRP_IDLE  = 3'b000,
      SRP_START = 3'b001,
      SRP_DATA  = 3'b010,
      SRP_STOP  = 3'b011,
      SRP_WAKE  = 3'b100
   } srp_state_type;

   typedef struct packed {
      logic       framing_error_bit;
      logic [8:0] data;
   } srp_char_type;

   typedef struct packed {
      logic [3:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } srp_bus_type;
endpackage : srp_pkg

// file: rtl/srp_receiver.sv
// serial receiver path: async, sync master and sync slave reception with two-character fifo
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ns
`include "srp_cfg.svh"

module srp_receiver #(
   parameter int DATA_BITS = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         srst,
   input  wire logic [3:0]   bus_addr,
   input  wire logic [15:0]  bus_wdata,
   input  wire logic         bus_wr,
   input  wire logic         bus_rd,
   output logic      [15:0]  bus_rdata,
   input  wire logic         data_pin_in,
   output logic              data_pin_out,
   output logic              data_pin_oe,
   input  wire logic         clock_pin_in,
   output logic              clock_pin_out,
   output logic              clock_pin_oe,
   output logic              receive_flag,
   output logic              irq
);
   // ==========================================================
   // registers
   logic [11:0] ctrl_reg;
   logic [15:0] baud_reg;
   srp_pkg::srp_bus_type bus;
   assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

   wire sel_ctrl = bus.addr == `SRP_CTRL_OFS;
   wire sel_stat = bus.addr == `SRP_STAT_OFS;
   wire sel_data = bus.addr == `SRP_DATA_OFS;
   wire sel_baud = bus.addr == `SRP_BAUD_OFS;
   wire serial_port_enable   = ctrl_reg[`SRP_CTRL_SERIAL_PORT_ENABLE];
   wire continuous_receive_enable   = ctrl_reg[`SRP_CTRL_CONTINUOUS_RECEIVE_ENABLE];
   wire single_receive_enable   = ctrl_reg[`SRP_CTRL_SINGLE_RECEIVE_ENABLE];
   wire rx9    = ctrl_reg[`SRP_CTRL_RX9];
   wire address_detect_enable  = ctrl_reg[`SRP_CTRL_ADDRESS_DETECT_ENABLE];
   wire syncm  = ctrl_reg[`SRP_CTRL_SYNC];
   wire master = ctrl_reg[`SRP_CTRL_MASTER];
   wire wake_en = ctrl_reg[`SRP_CTRL_WAKE];
   wire sleep  = ctrl_reg[`SRP_CTRL_SLEEP];

   // ==========================================================
   // pin synchronisers
   logic [1:0] dsync_reg;
   logic [1:0] csync_reg;
   logic       dprev_reg;
   logic       cprev_reg;
   always_ff @(posedge sys_clk) begin
      dsync_reg <= {dsync_reg[0], data_pin_in};
      csync_reg <= {csync_reg[0], clock_pin_in};
      dprev_reg <= dsync_reg[1];
      cprev_reg <= csync_reg[1];
   end
   wire rxd       = dsync_reg[1];
   wire d_edge    = rxd != dprev_reg;
   wire ck_fall   = cprev_reg & ~csync_reg[1];

   // ==========================================================
   // fifo, two entries
   srp_pkg::srp_char_type fifo_mem [0:`SRP_FIFO_DEPTH-1];
   logic       rd_ptr_reg;
   logic       wr_ptr_reg;
   logic [1:0] count_reg;
   logic       overrun_error_bit_reg;
   srp_pkg::srp_char_type top;
   assign top = fifo_mem[rd_ptr_reg];

   // pop happens on a data read; status must be read first
   wire pop  = bus.rd & sel_data & (count_reg != 2'd0);
   logic       done;
   srp_pkg::srp_char_type done_char;
   // address detect, with nine-bit receive on, drops characters whose ninth bit is clear
   wire keep = ~(address_detect_enable & rx9) | done_char.data[8];
   wire accept = done & keep & ~overrun_error_bit_reg;
   wire full_now = (count_reg == 2'd2) & ~pop;
   wire push = accept & ~full_now;

   always_ff @(posedge sys_clk) begin
      if (srst | ~serial_port_enable) begin
         rd_ptr_reg <= 1'b0;
         wr_ptr_reg <= 1'b0;
         count_reg  <= 2'd0;
         fifo_mem[0] <= '0;
         fifo_mem[1] <= '0;
      end else begin
         if (push) begin
            fifo_mem[wr_ptr_reg] <= done_char;
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop)
            rd_ptr_reg <= ~rd_ptr_reg;
         count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   // overrun: only continuous or port enable clear it
   always_ff @(posedge sys_clk) begin
      if (srst | ~serial_port_enable | ~continuous_receive_enable)
         overrun_error_bit_reg <= 1'b0;
      else if (accept & full_now)
         overrun_error_bit_reg <= 1'b1;
   end

   // ==========================================================
   // flags and interrupt
   wire rx_enabled = serial_port_enable & (continuous_receive_enable | single_receive_enable | (syncm & ~master));
   logic wake_int_reg;
   wire fifo_flag = rx_enabled & (count_reg != 2'd0);
   // a pending wake-up reports through the same flag so it reaches the processor
   assign receive_flag = fifo_flag | (serial_port_enable & wake_int_reg);
   wire framing_error_bit_bit  = (count_reg != 2'd0) & top.framing_error_bit;
   wire brk = fifo_flag & framing_error_bit_bit & (top.data[7:0] == 8'h00);
   // framing error does not feed irq
   assign irq = receive_flag & ctrl_reg[`SRP_CTRL_RXIE] & ctrl_reg[`SRP_CTRL_PERIPHERAL_IRQ_ENABLE]
                & ctrl_reg[`SRP_CTRL_GIE];

   // ==========================================================
   // baud tick: async oversample 16 and master clock half periods
   logic [15:0] bcnt_reg;
   wire tick = (bcnt_reg == baud_reg);
   always_ff @(posedge sys_clk) begin
      if (srst | tick)
         bcnt_reg <= 16'h0000;
      else
         bcnt_reg <= bcnt_reg + 16'h0001;
   end

   // ==========================================================
   // receive state machine
   srp_pkg::srp_state_type state_reg;
   logic [3:0] os_reg;
   logic [3:0] bit_reg;
   logic [8:0] rsr_reg;
   logic       ck_reg;
   logic       single_receive_enable_clr;
   logic       wake_hit;
   logic [1:0] wedge_reg;
   wire [3:0] nbits = rx9 ? 4'(DATA_BITS + 1) : 4'(DATA_BITS);
   wire master_run = syncm & master & (continuous_receive_enable | single_receive_enable);
   // in sleep only the externally clocked slave keeps going
   wire halted = sleep & ~(syncm & ~master);
   wire ck_trail = master ? (tick & ck_reg) : ck_fall;
   wire [8:0] rsr_shift = {rxd, rsr_reg[8:1]};
   wire [8:0] aligned = rx9 ? rsr_shift : {1'b0, rsr_shift[8:1]};

   always_ff @(posedge sys_clk) begin
      done <= 1'b0;
      single_receive_enable_clr <= 1'b0;
      wake_hit <= 1'b0;
      if (srst | ~serial_port_enable | halted) begin
         if (srst | ~serial_port_enable) begin
            state_reg <= srp_pkg::SRP_IDLE;
         end
         ck_reg <= 1'b0;
      end else if (syncm) begin
         if (master & ~master_run) begin
            state_reg <= srp_pkg::SRP_IDLE;
            ck_reg <= 1'b0;
            bit_reg <= 4'd0;
         end else begin
            if (state_reg != srp_pkg::SRP_DATA) begin
               state_reg <= srp_pkg::SRP_DATA;
               bit_reg <= 4'd0;
            end
            if (master & tick)
               ck_reg <= ~ck_reg;
            if (ck_trail & state_reg == srp_pkg::SRP_DATA) begin
               rsr_reg <= rsr_shift;
               if (bit_reg == nbits - 4'd1) begin
                  bit_reg <= 4'd0;
                  done <= 1'b1;
                  done_char <= '{framing_error_bit: 1'b0, data: aligned};
                  if (single_receive_enable)
                     single_receive_enable_clr <= 1'b1;
               end else
                  bit_reg <= bit_reg + 4'd1;
            end
         end
      end else if (continuous_receive_enable) begin
         case (state_reg)
            srp_pkg::SRP_IDLE: begin
               os_reg <= 4'd0;
               wedge_reg <= 2'd0;
               if (wake_en)
                  state_reg <= srp_pkg::SRP_WAKE;
               else if (~rxd)
                  state_reg <= srp_pkg::SRP_START;
            end
            srp_pkg::SRP_WAKE: begin
               if (d_edge) begin
                  wedge_reg <= wedge_reg + 2'd1;
                  if (wedge_reg == 2'd1) begin
                     wake_hit <= 1'b1;
                     state_reg <= srp_pkg::SRP_IDLE;
                  end
               end
            end
            srp_pkg::SRP_START: if (tick) begin
               os_reg <= os_reg + 4'd1;
               if (os_reg == 4'd7) begin
                  os_reg <= 4'd0;
                  bit_reg <= 4'd0;
                  state_reg <= rxd ? srp_pkg::SRP_IDLE : srp_pkg::SRP_DATA;
               end
            end
            srp_pkg::SRP_DATA: if (tick) begin
               os_reg <= os_reg + 4'd1;
               if (os_reg == 4'd15) begin
                  rsr_reg <= rsr_shift;
                  bit_reg <= bit_reg + 4'd1;
                  if (bit_reg == nbits - 4'd1)
                     state_reg <= srp_pkg::SRP_STOP;
               end
            end
            srp_pkg::SRP_STOP: if (tick) begin
               os_reg <= os_reg + 4'd1;
               if (os_reg == 4'd15) begin
                  done <= 1'b1;
                  done_char <= '{framing_error_bit: ~rxd, data: rx9 ? rsr_reg : {1'b0, rsr_reg[8:1]}};
                  state_reg <= srp_pkg::SRP_IDLE;
               end
            end
            default: state_reg <= srp_pkg::SRP_IDLE;
         endcase
      end else begin
         state_reg <= srp_pkg::SRP_IDLE;
      end
   end

   // ==========================================================
   // wake-on-break request
   // held until status is read, so a one-cycle hit is never missed by a sleeping core
   wire stat_rd = bus.rd & sel_stat;

   always_ff @(posedge sys_clk) begin
      if (srst | ~serial_port_enable)
         wake_int_reg <= 1'b0;
      else if (wake_hit)
         wake_int_reg <= 1'b1;
      else if (stat_rd)
         wake_int_reg <= 1'b0;
   end

   // ==========================================================
   // control register
   // a software write wins over a self-clear in the same cycle, so a fresh single
   // receive request is never lost to the end of the previous character
   wire        ctrl_wr = bus.wr & sel_ctrl;
   wire        baud_wr = bus.wr & sel_baud;
   wire [11:0] single_receive_enable_mask;
   wire [11:0] wake_mask;
   wire [11:0] hw_clr_mask;
   wire [11:0] ctrl_next;
   assign single_receive_enable_mask   = {11'h000, single_receive_enable_clr} << `SRP_CTRL_SINGLE_RECEIVE_ENABLE;
   assign wake_mask   = {11'h000, wake_hit} << `SRP_CTRL_WAKE;
   assign hw_clr_mask = single_receive_enable_mask | wake_mask;
   assign ctrl_next   = ctrl_wr ? bus.wdata[11:0] : (ctrl_reg & ~hw_clr_mask);

   always_ff @(posedge sys_clk) begin
      if (srst)
         ctrl_reg <= `SRP_CTRL_RST;
      else
         ctrl_reg <= ctrl_next;
   end

   // ==========================================================
   // baud divisor
   always_ff @(posedge sys_clk) begin
      if (srst)
         baud_reg <= `SRP_BAUD_RST;
      else if (baud_wr)
         baud_reg <= bus.wdata;
   end

   // ==========================================================
   // register map, as seen by software
   //   control  : bit 0  port enable
   //              bit 1  continuous receive
   //              bit 2  single receive, clears itself after one character
   //              bit 3  nine-bit receive
   //              bit 4  address detect
   //              bit 5  synchronous mode
   //              bit 6  synchronous master
   //              bit 7  wake on break, clears itself after the wake-up
   //              bit 8  receive interrupt enable
   //              bit 9  peripheral interrupt enable
   //              bit 10 global interrupt enable
   //              bit 11 sleep
   //   status   : bit 0 receive flag, bit 1 framing error, bit 2 overrun
   //              bit 3 ninth bit, bit 4 break seen, bit 5 wake-up pending
   //              bit 6 receiver busy
   //   data     : low byte of the top character; reading it advances the fifo
   //   baud     : divisor; tick period is divisor plus one system clocks

   // ==========================================================
   // read path
   wire        fifo_has  = count_reg != 2'd0;
   wire        ninth_bit = fifo_has & top.data[8];
   wire        rx_busy   = state_reg != srp_pkg::SRP_IDLE;
   wire [15:0] ctrl_word;
   wire [15:0] data_word;
   wire [15:0] rdata_next;
   logic [15:0] stat_word;

   always_comb begin
      stat_word                  = 16'h0000;
      stat_word[`SRP_STAT_FLAG]  = receive_flag;
      stat_word[`SRP_STAT_FRAMING_ERROR_BIT]  = framing_error_bit_bit;
      stat_word[`SRP_STAT_OVERRUN_ERROR_BIT]  = overrun_error_bit_reg;
      stat_word[`SRP_STAT_D9]    = ninth_bit;
      stat_word[`SRP_STAT_BREAK] = brk;
      stat_word[`SRP_STAT_WAKE]  = wake_int_reg;
      stat_word[`SRP_STAT_BUSY]  = rx_busy;
   end

   assign ctrl_word = {4'h0, ctrl_reg};
   // an empty fifo reads zero rather than a stale character
   assign data_word = fifo_has ? {8'h00, top.data[7:0]} : 16'h0000;
   assign rdata_next = ~bus.rd  ? 16'h0000 :
                       sel_ctrl ? ctrl_word :
                       sel_stat ? stat_word :
                       sel_data ? data_word :
                       sel_baud ? baud_reg :
                                  16'h0000;

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (srst)
         bus_rdata <= 16'h0000;
      else
         bus_rdata <= rdata_next;
   end

   // ==========================================================
   // pins
   // the receiver never drives the data pin; a transmitter elsewhere owns it
   assign data_pin_out  = 1'b0;
   assign data_pin_oe   = 1'b0;
   assign clock_pin_out = ck_reg;
   // only a synchronous master drives the clock pin; a slave listens
   assign clock_pin_oe  = serial_port_enable & syncm & master;

endmodule : srp_receiver

// file: tb/srp_peer.sv
// far-side model: synchronous master that clocks characters into the receiver
`timescale 1ns/1ns
module srp_peer (
   output logic ck,
   output logic dt
);
   initial begin
      ck = 1'b0;
      dt = 1'b1;
   end
   // ==========================================
   // character shifter, lsb first, clock idle low and still between frames
   task automatic send(input logic [8:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         // data moves with the leading edge and stands across the trailing one
         dt = w[i];
         ck = 1'b1;
         #80 ck = 1'b0;
         #80;
      end
      // released line: show the inverse so a stale level never passes for data
      #80 dt = ~dt;
   endtask : send
   // asynchronous frame at 160 ns a bit: start, eight bits lsb first, chosen stop level
   task automatic frame(input logic [7:0] w, input logic stop);
      dt = 1'b0;
      #160;
      for (int i = 0; i < 8; i++) begin
         dt = w[i];
         #160;
      end
      dt = stop;
      #160 dt = 1'b1;
      #320;
   endtask : frame
endmodule : srp_peer

// file: tb/srp_receiver_sva.sv
// port-level assertions for the serial receiver path
`timescale 1ns/1ns
`include "srp_cfg.svh"
module srp_receiver_sva (
   input wire logic        sys_clk,
   input wire logic        srst,
   input wire logic [3:0]  bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic        bus_wr,
   input wire logic        bus_rd,
   input wire logic [15:0] bus_rdata,
   input wire logic        data_pin_oe,
   input wire logic        clock_pin_out,
   input wire logic        clock_pin_oe,
   input wire logic        receive_flag,
   input wire logic        irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   logic [11:0] ctl_reg;
   wire ctl_wr  = bus_wr && bus_addr == `SRP_CTRL_OFS;
   wire stat_rd = bus_rd && bus_addr == `SRP_STAT_OFS;
   wire sync_on = ctl_reg[`SRP_CTRL_SERIAL_PORT_ENABLE] && ctl_reg[`SRP_CTRL_SYNC];
   wire ien     = ctl_reg[`SRP_CTRL_RXIE] && ctl_reg[`SRP_CTRL_PERIPHERAL_IRQ_ENABLE] && ctl_reg[`SRP_CTRL_GIE];
   wire w_stop  = bus_wdata[`SRP_CTRL_MASTER] && !bus_wdata[`SRP_CTRL_CONTINUOUS_RECEIVE_ENABLE] && !bus_wdata[`SRP_CTRL_SINGLE_RECEIVE_ENABLE];
   // shadow of control; self-clearing of single receive is not mirrored, so no property leans on it
   always_ff @(posedge sys_clk) begin
      if (srst)
         ctl_reg <= `SRP_CTRL_RST;
      else if (ctl_wr)
         ctl_reg <= bus_wdata[11:0];
   end
   // ==========================================
   // properties
   property p_irq_flag; irq |-> receive_flag; endproperty
   property p_irq_en; irq |-> ien; endproperty
   property p_serial_port_enable_off; !ctl_reg[`SRP_CTRL_SERIAL_PORT_ENABLE] |=> !receive_flag; endproperty
   property p_stat_flag; stat_rd |=> bus_rdata[`SRP_STAT_FLAG] == $past(receive_flag); endproperty
   property p_break;
      $past(stat_rd) && bus_rdata[`SRP_STAT_BREAK] |-> bus_rdata[`SRP_STAT_FLAG] && bus_rdata[`SRP_STAT_FRAMING_ERROR_BIT];
   endproperty
   property p_master_oe; sync_on && ctl_reg[`SRP_CTRL_MASTER] && ctl_reg[`SRP_CTRL_CONTINUOUS_RECEIVE_ENABLE] |-> !data_pin_oe; endproperty
   property p_slave_ck; sync_on && !ctl_reg[`SRP_CTRL_MASTER] |-> !clock_pin_oe; endproperty
   property p_continuous_receive_enable_stop; ctl_wr && sync_on && w_stop |-> ##3 $stable(clock_pin_out)[*4]; endproperty
   a_irq_flag:  assert property (p_irq_flag) else $error("irq without receive flag");
   a_irq_en:    assert property (p_irq_en) else $error("irq with an enable clear");
   a_serial_port_enable_off:  assert property (p_serial_port_enable_off) else $error("flag with port disabled");
   a_stat_flag: assert property (p_stat_flag) else $error("status flag differs from pin");
   a_break:     assert property (p_break) else $error("break without flag and framing");
   a_master_oe: assert property (p_master_oe) else $error("data driver on in master receive");
   a_slave_ck:  assert property (p_slave_ck) else $error("clock driven in slave mode");
   a_continuous_receive_enable_stop: assert property (p_continuous_receive_enable_stop) else $error("clock runs after receive stop");
   c_irq:  cover property (irq);
   c_flag: cover property (receive_flag);
   c_ovr:  cover property (stat_rd ##1 bus_rdata[`SRP_STAT_OVERRUN_ERROR_BIT]);
endmodule : srp_receiver_sva

// file: tb/srp_receiver_tb.sv
// self-checking bench for the serial receiver path, mostly synchronous slave receive
`timescale 1ns/1ns
`include "srp_cfg.svh"
module srp_receiver_tb;
   logic        sys_clk, srst, bus_wr, bus_rd, data_pin_out, data_pin_oe;
   logic        clock_pin_out, clock_pin_oe, receive_flag, irq, pk, pd;
   logic [3:0]  bus_addr;
   logic [15:0] bus_wdata, bus_rdata, v;
   int          err_total, samples_checked, cyc;
   wire dl = data_pin_oe ? data_pin_out : pd;
   wire cl = clock_pin_oe ? clock_pin_out : pk;
   // port on, continuous receive, synchronous slave
   localparam logic [15:0] SL = 16'h0023;
   srp_peer peer_u (.ck(pk), .dt(pd));
   srp_receiver dut_u (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .data_pin_in(dl), .data_pin_out(data_pin_out),
      .data_pin_oe(data_pin_oe), .clock_pin_in(cl), .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe),
      .receive_flag(receive_flag), .irq(irq));
   // ==========================================
   // bus and check tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      bus_wr    <= 1'b1;
      bus_addr  <= a;
      bus_wdata <= d;
      @(posedge sys_clk);
      bus_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk);
      bus_rd   <= 1'b1;
      bus_addr <= a;
      @(posedge sys_clk);
      bus_rd <= 1'b0;
      #1 v = bus_rdata;
   endtask : rd
   task automatic cfg(input logic [15:0] d);
      wr(`SRP_CTRL_OFS, 16'h0000);
      wr(`SRP_CTRL_OFS, d);
   endtask : cfg
   task automatic rx(input logic [8:0] w, input int n);
      peer_u.send(w, n);
      for (int i = 0; i < 40 && receive_flag !== 1'b1; i++)
         @(posedge sys_clk);
   endtask : rx
   // ==========================================
   // scenarios
   task automatic t_basic;
      rd(`SRP_CTRL_OFS);
      chk(16'(v[11:0]), 16'(`SRP_CTRL_RST));
      rd(4'hf);
      cfg(SL | 16'h0800);
      rx(9'h0a5, 8);
      chk(16'(receive_flag), 16'h0001);
      rd(`SRP_STAT_OFS);
      chk(16'(v[`SRP_STAT_FLAG]), 16'h0001);
      rd(`SRP_DATA_OFS);
      chk(16'(v[7:0]), 16'h00a5);
      repeat (2) @(posedge sys_clk);
      chk(16'(receive_flag), 16'h0000);
   endtask : t_basic
   task automatic t_nine;
      cfg(SL | 16'h0008);
      rx(9'h13c, 9);
      rd(`SRP_STAT_OFS);
      chk(16'(v[`SRP_STAT_D9]), 16'h0001);
      rd(`SRP_DATA_OFS);
      chk(16'(v[7:0]), 16'h003c);
   endtask : t_nine
   task automatic t_addr;
      cfg(SL | 16'h0018);
      rx(9'h055, 9);
      chk(16'(receive_flag), 16'h0000);
      rx(9'h1aa, 9);
      chk(16'(receive_flag), 16'h0001);
      rd(`SRP_DATA_OFS);
      chk(16'(v[7:0]), 16'h00aa);
      wr(`SRP_CTRL_OFS, SL | 16'h0008);
      rx(9'h055, 9);
      rd(`SRP_DATA_OFS);
      chk(16'(v[7:0]), 16'h0055);
   endtask : t_addr
   task automatic t_ovr;
      cfg(SL);
      rx(9'h011, 8);
      rx(9'h022, 8);
      rx(9'h033, 8);
      rd(`SRP_STAT_OFS);
      chk(16'(v[`SRP_STAT_OVERRUN_ERROR_BIT]), 16'h0001);
      rd(`SRP_DATA_OFS);
      chk(16'(v[7:0]), 16'h0011);
      rd(`SRP_DATA_OFS);
      chk(16'(v[7:0]), 16'h0022);
      repeat (2) @(posedge sys_clk);
      chk(16'(receive_flag), 16'h0000);
      wr(`SRP_CTRL_OFS, 16'h0021);
      rd(`SRP_STAT_OFS);
      chk(16'(v[`SRP_STAT_OVERRUN_ERROR_BIT]), 16'h0000);
   endtask : t_ovr
   task automatic t_irq_serial_port_enable;
      cfg(SL | 16'h0700);
      rx(9'h05a, 8);
      repeat (2) @(posedge sys_clk);
      chk(16'(irq), 16'h0001);
      wr(`SRP_CTRL_OFS, SL | 16'h0300);
      @(posedge sys_clk);
      chk(16'(irq), 16'h0000);
      wr(`SRP_CTRL_OFS, 16'h0000);
      wr(`SRP_CTRL_OFS, SL);
      repeat (2) @(posedge sys_clk);
      chk(16'(receive_flag), 16'h0000);
      rd(`SRP_STAT_OFS);
      chk(16'(v[`SRP_STAT_FRAMING_ERROR_BIT]), 16'h0000);
   endtask : t_irq_serial_port_enable
   task automatic t_master;
      wr(`SRP_BAUD_OFS, 16'h0003);
      cfg(16'h0063);
      repeat (40) @(posedge sys_clk);
      chk(16'(data_pin_oe), 16'h0000);
      wr(`SRP_CTRL_OFS, 16'h0061);
      repeat (10) @(posedge sys_clk);
      wr(`SRP_CTRL_OFS, 16'h0065);
      repeat (100) @(posedge sys_clk);
      rd(`SRP_CTRL_OFS);
      chk(16'(v[`SRP_CTRL_SINGLE_RECEIVE_ENABLE]), 16'h0000);
      chk(16'(clock_pin_out), 16'h0000);
   endtask : t_master
   task automatic t_break;
      cfg(16'h0003);
      peer_u.frame(8'h00, 1'b0);
      for (int i = 0; i < 40 && receive_flag !== 1'b1; i++)
         @(posedge sys_clk);
      rd(`SRP_STAT_OFS);
      chk(16'(v[`SRP_STAT_FLAG]), 16'h0001);
      chk(16'(v[`SRP_STAT_FRAMING_ERROR_BIT]), 16'h0001);
      chk(16'(v[`SRP_STAT_BREAK]), 16'h0001);
      wr(`SRP_CTRL_OFS, 16'h0001);
      rd(`SRP_STAT_OFS);
      chk(16'(v[`SRP_STAT_FRAMING_ERROR_BIT]), 16'h0001);
      rd(`SRP_DATA_OFS);
      chk(16'(v[7:0]), 16'h0000);
      wr(`SRP_CTRL_OFS, 16'h0000);
      rd(`SRP_STAT_OFS);
      chk(16'(v[`SRP_STAT_FRAMING_ERROR_BIT]), 16'h0000);
   endtask : t_break
   // ==========================================
   // clock, timeout, verdict and main sequence
   task automatic finish_test;
      if (err_total == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         finish_test();
      end
   end
   initial begin
      srst      = 1'b1;
      bus_wr    = 1'b0;
      bus_rd    = 1'b0;
      bus_addr  = 4'h0;
      bus_wdata = 16'h0000;
      repeat (2) @(posedge sys_clk);
      srst <= 1'b0;
      t_basic();
      t_nine();
      t_addr();
      t_ovr();
      t_irq_serial_port_enable();
      t_break();
      t_master();
      finish_test();
   end
endmodule : srp_receiver_tb
bind srp_receiver srp_receiver_sva chk_u (.sys_clk(sys_clk), .srst(srst), .bus_addr(bus_addr),
   .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .data_pin_oe(data_pin_oe),
   .clock_pin_out(clock_pin_out), .clock_pin_oe(clock_pin_oe), .receive_flag(receive_flag), .irq(irq));
